// ==== supervisor_ctrl.sv ====
// watchdog control tail and supply monitor control/status registers
`default_nettype none
module supervisor_ctrl
  import supervisor_pkg::*;
#(
  parameter int WD_TIMEOUT = WD_TIMEOUT_CYCLES,
  parameter int RELEASE = RELEASE_CYCLES,
  parameter int GLITCH = GLITCH_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic comparator_i,
  input wire logic psm_irq_enable_i,
  output logic [1:0] trip_select_o,
  output logic monitor_enable_o,
  output logic psm_irq_o,
  output logic wd_irq_o,
  output logic wd_reset_o
);
  localparam int WD_W = $clog2(WD_TIMEOUT + 1);
  localparam logic [WD_W-1:0] WD_LAST = WD_W'(WD_TIMEOUT - 1);

  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  logic wr_wd, wr_psm, accept;
  assign wr_wd = sfr_wr_i && (sfr_addr_i == WATCHDOG_CONTROL_ADDR);
  assign wr_psm = sfr_wr_i && (sfr_addr_i == SUPPLY_MONITOR_CONTROL_ADDR);

  // supply monitor: enable, trip select and the sticky low-supply flag
  logic [7:0] psm_q, psm_d;
  logic psm_irq_q, psm_irq_d;
  logic comp_low, low_qual, high_qual, psm_set_evt;

  // a disabled monitor feeds a low level to the filter, so no low supply can qualify
  assign comp_low = psm_q[PSM_ENABLE_BIT] && !comparator_i;

  // glitch filter on the low level
  rise_qualifier #(.COUNT(GLITCH)) low_filter (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .level_i(comp_low),
    .qualified_o(low_qual)
  );

  // release timer: supply must stay high the whole interval
  rise_qualifier #(.COUNT(RELEASE)) release_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .level_i(comparator_i),
    .qualified_o(high_qual)
  );

  // flag priority: write, then release, then set (set wins)
  always_comb begin
    psm_d = psm_q;
    if (wr_psm) begin
      psm_d[PSM_TRIP_HI_BIT] = sfr_wdata_i[PSM_TRIP_HI_BIT];
      psm_d[PSM_TRIP_LO_BIT] = sfr_wdata_i[PSM_TRIP_LO_BIT];
      psm_d[PSM_ENABLE_BIT] = sfr_wdata_i[PSM_ENABLE_BIT];
      if (sfr_wdata_i[PSM_IRQ_FLAG_BIT] || comparator_i) begin
        psm_d[PSM_IRQ_FLAG_BIT] = sfr_wdata_i[PSM_IRQ_FLAG_BIT];
      end
    end
    // release only while the comparator is still high this cycle
    if (high_qual && comparator_i) begin
      psm_d[PSM_IRQ_FLAG_BIT] = 1'b0;
    end
    if (low_qual) begin
      psm_d[PSM_IRQ_FLAG_BIT] = 1'b1;
    end
    psm_irq_d = psm_d[PSM_IRQ_FLAG_BIT] && psm_irq_enable_i;
  end
  // a fresh set of the flag is the supply interrupt event that stops the watchdog
  assign psm_set_evt = psm_d[PSM_IRQ_FLAG_BIT] && !psm_q[PSM_IRQ_FLAG_BIT];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      psm_q <= SUPPLY_MONITOR_CONTROL_RST;
      psm_irq_q <= 1'b0;
    end else begin
      psm_q <= psm_d;
      psm_irq_q <= psm_irq_d;
    end
  end

  // watchdog: write protection, control bits and timeout counter
  unlock_state_t unlock_q, unlock_d;
  logic [7:0] wd_q, wd_d;
  logic [WD_W-1:0] wd_cnt_q, wd_cnt_d;
  logic wd_irq_q, wd_irq_d, wd_rst_q, wd_rst_d, timeout;

  assign accept = wr_wd && (unlock_q == UNLOCK_ARMED);
  // prescaler field is stored but not decoded: one fixed timeout length
  assign timeout = wd_q[WD_ENABLE_REFRESH_BIT] && (wd_cnt_q == WD_LAST);

  // any write ends the armed window, so only the very next write counts
  always_comb begin
    unlock_d = unlock_q;
    unique case (unlock_q)
      UNLOCK_IDLE: begin
        if (wr_wd && sfr_wdata_i[WD_WRITE_UNLOCK_BIT]) begin
          unlock_d = UNLOCK_ARMED;
        end
      end
      UNLOCK_ARMED: begin
        if (sfr_wr_i) begin
          unlock_d = UNLOCK_IDLE;
        end
      end
      default: unlock_d = UNLOCK_IDLE;
    endcase
  end

  // control bits and counter; hardware events applied after the write
  always_comb begin
    wd_d = wd_q;
    wd_cnt_d = wd_q[WD_ENABLE_REFRESH_BIT] ? wd_cnt_q + WD_W'(1) : '0;
    if (accept) begin
      wd_d[7:WD_PRESCALE_LSB] = sfr_wdata_i[7:WD_PRESCALE_LSB];
      wd_d[WD_IRQ_SELECT_BIT] = sfr_wdata_i[WD_IRQ_SELECT_BIT];
      wd_d[WD_TIMEOUT_FLAG_BIT] = sfr_wdata_i[WD_TIMEOUT_FLAG_BIT];
      wd_d[WD_ENABLE_REFRESH_BIT] = sfr_wdata_i[WD_ENABLE_REFRESH_BIT];
      if (sfr_wdata_i[WD_ENABLE_REFRESH_BIT]) begin
        wd_cnt_d = '0;
      end
    end
    if (timeout) begin
      wd_cnt_d = '0;
      wd_d[WD_TIMEOUT_FLAG_BIT] = 1'b1;
      if (!wd_q[WD_IRQ_SELECT_BIT]) begin
        wd_d[WD_ENABLE_REFRESH_BIT] = 1'b0;
      end
    end
    if (psm_set_evt) begin
      wd_d[WD_ENABLE_REFRESH_BIT] = 1'b0;
    end
    wd_d[WD_WRITE_UNLOCK_BIT] = 1'b0;
    wd_rst_d = timeout && !wd_q[WD_IRQ_SELECT_BIT];
    wd_irq_d = timeout && wd_q[WD_IRQ_SELECT_BIT];
  end

  // this block sees hardware reset only, so a watchdog reset keeps the flag
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      unlock_q <= UNLOCK_IDLE;
      wd_q <= WATCHDOG_CONTROL_RST;
      wd_cnt_q <= '0;
      wd_irq_q <= 1'b0;
      wd_rst_q <= 1'b0;
    end else begin
      unlock_q <= unlock_d;
      wd_q <= wd_d;
      wd_cnt_q <= wd_cnt_d;
      wd_irq_q <= wd_irq_d;
      wd_rst_q <= wd_rst_d;
    end
  end

  // read port: registered, so read data lands one cycle after the strobe
  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd_i) begin
      if (sfr_addr_i == SUPPLY_MONITOR_CONTROL_ADDR) begin
        // reserved bits read back at their power-on pattern
        rdata_d = PSM_RESERVED_MASK;
        rdata_d[PSM_COMPARATOR_BIT] = comparator_i;
        rdata_d[PSM_IRQ_FLAG_BIT] = psm_q[PSM_IRQ_FLAG_BIT];
        rdata_d[PSM_TRIP_HI_BIT] = psm_q[PSM_TRIP_HI_BIT];
        rdata_d[PSM_TRIP_LO_BIT] = psm_q[PSM_TRIP_LO_BIT];
        rdata_d[PSM_ENABLE_BIT] = psm_q[PSM_ENABLE_BIT];
      end else if (sfr_addr_i == WATCHDOG_CONTROL_ADDR) begin
        rdata_d = wd_q;
        rdata_d[WD_WRITE_UNLOCK_BIT] = (unlock_q == UNLOCK_ARMED);
      end else begin
        rdata_d = 8'h00; // unmapped
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops
  assign sfr_rdata_o = rdata_q;
  assign trip_select_o = {psm_q[PSM_TRIP_HI_BIT], psm_q[PSM_TRIP_LO_BIT]};
  assign monitor_enable_o = psm_q[PSM_ENABLE_BIT];
  assign psm_irq_o = psm_irq_q;
  assign wd_irq_o = wd_irq_q;
  assign wd_reset_o = wd_rst_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence glitch_seq;
    (!wr_psm) throughout
      ((!psm_q[PSM_IRQ_FLAG_BIT] && comparator_i && !low_qual) ##1 !comparator_i ##1 comparator_i);
  endsequence

  sequence refresh_seq;
    accept && sfr_wdata_i[WD_ENABLE_REFRESH_BIT] && !timeout && !psm_set_evt;
  endsequence

  timeout_flag_a: assert property (timeout |=> wd_q[WD_TIMEOUT_FLAG_BIT])
    else $error("timeout did not set the flag");

  refresh_clears_a: assert property (refresh_seq |=> wd_cnt_q == '0 ##1 wd_cnt_q == WD_W'(1))
    else $error("refresh did not restart the count");

  reset_mode_a: assert property (timeout && !wd_q[WD_IRQ_SELECT_BIT] && !accept
    |=> wd_reset_o && !wd_irq_o && !wd_q[WD_ENABLE_REFRESH_BIT])
    else $error("reset-mode timeout misbehaved");

  locked_write_a: assert property (wr_wd && unlock_q == UNLOCK_IDLE
    |=> wd_q[WD_IRQ_SELECT_BIT] == $past(wd_q[WD_IRQ_SELECT_BIT]))
    else $error("locked watchdog write took effect");

  monitor_off_a: assert property (!psm_q[PSM_ENABLE_BIT] ##1
    (!psm_q[PSM_ENABLE_BIT] && !psm_q[PSM_IRQ_FLAG_BIT] && !wr_psm) |=> !psm_q[PSM_IRQ_FLAG_BIT])
    else $error("disabled monitor set the flag");

  trip_write_a: assert property (wr_psm |=> trip_select_o == $past(sfr_wdata_i[PSM_TRIP_HI_BIT:PSM_TRIP_LO_BIT]))
    else $error("trip select not taken");

  psm_request_a: assert property (psm_q[PSM_IRQ_FLAG_BIT] && !comparator_i && psm_irq_enable_i
    |=> psm_irq_o)
    else $error("low-supply flag gave no request");

  flag_hold_a: assert property (psm_q[PSM_IRQ_FLAG_BIT] && !comparator_i |=> psm_q[PSM_IRQ_FLAG_BIT])
    else $error("low-supply flag cleared while comparator low");

  release_wait_a: assert property ($fell(psm_q[PSM_IRQ_FLAG_BIT]) && !$past(wr_psm) |-> $past(high_qual))
    else $error("flag released before the interval");

  glitch_reject_a: assert property (glitch_seq |=> !psm_q[PSM_IRQ_FLAG_BIT])
    else $error("glitch set the low-supply flag");

  low_sets_a: assert property (low_qual |=> psm_q[PSM_IRQ_FLAG_BIT])
    else $error("qualified low did not set the flag");

  status_mirror_a: assert property (sfr_rd_i && sfr_addr_i == SUPPLY_MONITOR_CONTROL_ADDR
    |=> sfr_rdata_o[PSM_COMPARATOR_BIT] == $past(comparator_i))
    else $error("status bit does not mirror comparator");

  irq_mode_a: assert property (timeout && wd_q[WD_IRQ_SELECT_BIT] |=> wd_irq_o && !wd_reset_o)
    else $error("interrupt-mode timeout gave a reset");

  // the hardware clears below must win over anything written in the same cycle
  sequence release_seq;
    high_qual && comparator_i && !low_qual;
  endsequence

  unlock_single_a: assert property (unlock_q == UNLOCK_ARMED && sfr_wr_i |=> unlock_q == UNLOCK_IDLE)
    else $error("write window stayed open after a write");

  enable_write_zero_a: assert property (accept && !sfr_wdata_i[WD_ENABLE_REFRESH_BIT]
    |=> !wd_q[WD_ENABLE_REFRESH_BIT])
    else $error("written zero did not stop the watchdog");

  psm_drops_enable_a: assert property (psm_set_evt |=> !wd_q[WD_ENABLE_REFRESH_BIT])
    else $error("low-supply interrupt left the watchdog enabled");

  flag_kept_a: assert property (wd_reset_o |-> wd_q[WD_TIMEOUT_FLAG_BIT])
    else $error("timeout flag missing during the reset request");

  release_clears_a: assert property (release_seq |=> !psm_q[PSM_IRQ_FLAG_BIT])
    else $error("release interval ended but the flag stayed set");
endmodule
`default_nettype wire

// ==== supervisor_pkg.sv ====
// register map, field positions, reset values and timing for the supervisor block
`default_nettype none
package supervisor_pkg;
  // special function register addresses
  localparam logic [7:0] SUPPLY_MONITOR_CONTROL_ADDR = 8'hDF;
  localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hC0;

  // reset values
  localparam logic [7:0] SUPPLY_MONITOR_CONTROL_RST = 8'hDE;
  localparam logic [7:0] WATCHDOG_CONTROL_RST = 8'h00;

  // watchdog_control fields
  localparam int WD_PRESCALE_LSB = 4;
  localparam int WD_IRQ_SELECT_BIT = 3;
  localparam int WD_TIMEOUT_FLAG_BIT = 2;
  localparam int WD_ENABLE_REFRESH_BIT = 1;
  localparam int WD_WRITE_UNLOCK_BIT = 0;

  // supply_monitor_control fields
  localparam int PSM_COMPARATOR_BIT = 6;
  localparam int PSM_IRQ_FLAG_BIT = 5;
  localparam int PSM_TRIP_HI_BIT = 4;
  localparam int PSM_TRIP_LO_BIT = 3;
  localparam int PSM_ENABLE_BIT = 0;
  // reserved bits read back as their power-on value
  localparam logic [7:0] PSM_RESERVED_MASK = 8'h86;

  // timing
  localparam int CLK_MHZ = 125;
  localparam int RELEASE_MS = 250;
  localparam int GLITCH_NS = 64;
  localparam int WD_TIMEOUT_MS = 2000;
  localparam int RELEASE_CYCLES = RELEASE_MS * CLK_MHZ * 1000;
  localparam int WD_TIMEOUT_CYCLES = WD_TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int GLITCH_CYCLES = (GLITCH_NS * CLK_MHZ + 999) / 1000;

  // two-step write protection
  typedef enum logic [1:0] {
    UNLOCK_IDLE  = 2'b01,
    UNLOCK_ARMED = 2'b10
  } unlock_state_t;
endpackage
`default_nettype wire

// ==== rise_qualifier.sv ====
// qualifies a rising level: output rises after COUNT stable high cycles, falls at once
`default_nettype none
module rise_qualifier #(
  parameter int COUNT = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic qualified_o
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic qual_q, qual_d;

  // count consecutive high cycles; any low restarts the wait
  always_comb begin
    cnt_d = cnt_q;
    qual_d = qual_q;
    if (!level_i) begin
      cnt_d = '0;
      qual_d = 1'b0;
    end else if (!qual_q) begin
      if (cnt_q == LAST) begin
        qual_d = 1'b1;
      end else begin
        cnt_d = cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      qual_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      qual_q <= qual_d;
    end
  end

  assign qualified_o = qual_q;

  // output may only rise after the input stood high
  rise_needs_high_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(qual_q) |-> $past(level_i))
    else $error("qualified output rose without a high input");
endmodule
`default_nettype wire

// ==== supervisor_tb.sv ====
// register-level testbench for the watchdog and supply monitor control block
`default_nettype none
module testbench
  import supervisor_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WDT = 20;
  localparam int REL = 16;
  localparam int GL = 8;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic comparator_i = 1'b1;
  logic psm_irq_enable_i = 1'b1;
  logic [1:0] trip_select_o;
  logic monitor_enable_o;
  logic psm_irq_o;
  logic wd_irq_o;
  logic wd_reset_o;
  int bad_count = 0;
  int checks = 0;
  int n_rst = 0;
  int n_irq = 0;
  int r0;
  int i0;

  // short counts keep the run brief; expectations use the same values
  supervisor_ctrl #(.WD_TIMEOUT(WDT), .RELEASE(REL), .GLITCH(GL)) supervisor_ctrl_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .comparator_i(comparator_i), .psm_irq_enable_i(psm_irq_enable_i),
    .trip_select_o(trip_select_o), .monitor_enable_o(monitor_enable_o),
    .psm_irq_o(psm_irq_o), .wd_irq_o(wd_irq_o), .wd_reset_o(wd_reset_o)
  );

  always #4 clk_i = ~clk_i;

  // pulse counters, sampled away from the launching edge
  always @(negedge clk_i) begin
    if (wd_reset_o === 1'b1) n_rst++;
    if (wd_irq_o === 1'b1) n_irq++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one idle cycle between strobes so no signal is driven twice in a step
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask

  // arm the two-step protection, then write the watchdog register
  task automatic wd_write(input logic [7:0] d);
    sfr_write(WATCHDOG_CONTROL_ADDR, 8'h01);
    sfr_write(WATCHDOG_CONTROL_ADDR, d);
  endtask

  // read one register and compare the bits under the mask
  task automatic read_expect(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] d;
    sfr_read(a, d);
    chk(d & mask, exp);
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_i);
    // reset values, unmapped address
    read_expect(SUPPLY_MONITOR_CONTROL_ADDR, 8'hFF, 8'hDE);
    read_expect(WATCHDOG_CONTROL_ADDR, 8'hFF, 8'h00);
    read_expect(8'h55, 8'hFF, 8'h00);
    chk({6'h00, trip_select_o}, 8'h03);
    chk({7'h00, monitor_enable_o}, 8'h00);
    // unprotected write and a write after an intervening write to another address are refused
    sfr_write(WATCHDOG_CONTROL_ADDR, 8'h72);
    sfr_write(WATCHDOG_CONTROL_ADDR, 8'h01);
    sfr_write(8'h55, 8'h00);
    sfr_write(WATCHDOG_CONTROL_ADDR, 8'h72);
    read_expect(WATCHDOG_CONTROL_ADDR, 8'hFE, 8'h00);
    // reset-mode timeout: pulse, flag set, enable cleared
    r0 = n_rst;
    wd_write(8'h72);
    read_expect(WATCHDOG_CONTROL_ADDR, 8'hFF, 8'h72);
    repeat (WDT + 4) @(negedge clk_i);
    chk(8'(n_rst - r0), 8'h01);
    chk(8'(n_irq), 8'h00);
    read_expect(WATCHDOG_CONTROL_ADDR, 8'hFF, 8'h74);
    // regular refresh keeps the timeout away
    r0 = n_rst;
    for (int k = 0; k < 6; k++) begin
      wd_write(8'h72);
      repeat (6) @(negedge clk_i);
    end
    chk(8'(n_rst - r0), 8'h00);
    // writing 0 to the enable stops the watchdog
    wd_write(8'h70);
    repeat (WDT + 10) @(negedge clk_i);
    chk(8'(n_rst - r0), 8'h00);
    // interrupt mode: interrupt instead of reset, enable stays
    i0 = n_irq;
    wd_write(8'h7A);
    repeat (WDT + 4) @(negedge clk_i);
    chk(8'(n_irq - i0), 8'h01);
    chk(8'(n_rst - r0), 8'h00);
    read_expect(WATCHDOG_CONTROL_ADDR, 8'h0E, 8'h0E);
    // every trip code reaches the output
    for (int t = 0; t < 4; t++) begin
      sfr_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'(t << 3) | 8'h01);
      chk({6'h00, trip_select_o}, 8'(t));
      chk({7'h00, monitor_enable_o}, 8'h01);
    end
    // status bit is live and read-only; a short dip does not latch
    sfr_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h19);
    read_expect(SUPPLY_MONITOR_CONTROL_ADDR, 8'hFF, 8'hDF);
    comparator_i = 1'b0;
    read_expect(SUPPLY_MONITOR_CONTROL_ADDR, 8'hFF, 8'h9F);
    comparator_i = 1'b1;
    repeat (GL - 4) @(negedge clk_i);
    comparator_i = 1'b0;
    repeat (GL - 1) @(negedge clk_i);
    comparator_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk({7'h00, psm_irq_o}, 8'h00);
    read_expect(SUPPLY_MONITOR_CONTROL_ADDR, 8'hFF, 8'hDF);
    // sustained low sets the flag and drops the watchdog enable
    comparator_i = 1'b0;
    repeat (GL + 3) @(negedge clk_i);
    chk({7'h00, psm_irq_o}, 8'h01);
    read_expect(SUPPLY_MONITOR_CONTROL_ADDR, 8'hFF, 8'hBF);
    read_expect(WATCHDOG_CONTROL_ADDR, 8'h02, 8'h00);
    // software clear refused while still low
    sfr_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h19);
    read_expect(SUPPLY_MONITOR_CONTROL_ADDR, 8'hFF, 8'hBF);
    // interrupt request follows the external enable
    psm_irq_enable_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk({7'h00, psm_irq_o}, 8'h00);
    psm_irq_enable_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk({7'h00, psm_irq_o}, 8'h01);
    // flag holds through most of the release interval, then clears
    comparator_i = 1'b1;
    repeat (REL - 4) @(negedge clk_i);
    read_expect(SUPPLY_MONITOR_CONTROL_ADDR, 8'hFF, 8'hFF);
    repeat (8) @(negedge clk_i);
    read_expect(SUPPLY_MONITOR_CONTROL_ADDR, 8'hFF, 8'hDF);
    chk({7'h00, psm_irq_o}, 8'h00);
    // disabled monitor ignores a low supply
    sfr_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h18);
    chk({7'h00, monitor_enable_o}, 8'h00);
    comparator_i = 1'b0;
    repeat (GL + 12) @(negedge clk_i);
    read_expect(SUPPLY_MONITOR_CONTROL_ADDR, 8'hFF, 8'h9E);
    chk({7'h00, psm_irq_o}, 8'h00);
    comparator_i = 1'b1;
    end_of_test();
  end
endmodule
`default_nettype wire
